// ### inc/sdv_pkg.sv
package sdv_pkg;
   // APB word offsets
   localparam logic [7:0] ADDR_CFG0 = 8'h00;
   localparam logic [7:0] ADDR_CFG1 = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;

   // Config word 0 fields
   localparam int FRAC_LSB = 4;
   localparam int FRAC_W = 15;
   localparam int INT_LSB = 19;
   localparam int INT_W = 8;
   localparam int MUX_LSB = 29;
   localparam int MUX_W = 3;

   // Config word 1 fields
   localparam int RDIV_LSB = 4;
   localparam int RDIV_W = 3;
   localparam int CKDIV_LSB = 7;
   localparam int CKDIV_W = 4;
   localparam int OSCEN_BIT = 12;
   localparam int BIAS_LSB = 13;
   localparam int BIAS_W = 2;
   localparam int HALF_BIT = 18;

   // Values after reset or power-enable low, and the least valid integer
   localparam logic [FRAC_W-1:0] FRAC_RST = 15'h0000;
   localparam logic [INT_W-1:0] INT_MIN = 8'h17;
   localparam logic [INT_W-1:0] INT_RST = 8'h17;
   localparam logic [RDIV_W-1:0] RDIV_RST = 3'h1;
   localparam logic [CKDIV_W-1:0] CKDIV_RST = 4'h4;
   localparam logic OSCEN_RST = 1'b1;
   localparam logic [BIAS_W-1:0] BIAS_RST = 2'h0;
   localparam logic HALF_RST = 1'b0;

   // Status source select codes
   localparam logic [MUX_W-1:0] SEL_REG_READY = 3'h0;
   localparam logic [MUX_W-1:0] SEL_CAL_DONE = 3'h1;
   localparam logic [MUX_W-1:0] SEL_LOCK = 3'h2;
   localparam logic [MUX_W-1:0] SEL_TXRX = 3'h3;

   // Lock detect: phase error figures in ns, cycles to lock
   localparam int LOCK_ERR_NS = 15;
   localparam int UNLOCK_ERR_NS = 25;
   localparam int LOCK_CYCLES = 5;
endpackage

// ### hw/sdv_divided_ref_output_div.sv
`timescale 1ns/1ps
module sdv_outclk_div #(
   parameter int DIV_W = 4
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Control
   input wire logic [DIV_W-1:0] half_period_i,
   // Output
   output logic clk_div_o,
   output logic running_o
);
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;
   logic out_q;
   logic out_d;
   wire stopped = (half_period_i == '0);
   wire wrap = (cnt_q >= half_period_i - DIV_W'(1));

   // Ratio is twice the field, equal high and low halves
   assign cnt_d = (stopped || wrap) ? '0 : cnt_q + DIV_W'(1);
   // Output starts high and first falls on reference edge number half_period_i
   assign out_d = stopped ? 1'b0 : (wrap ? ~out_q : out_q);

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cnt_q <= '0;
         out_q <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign clk_div_o = out_q;
   assign running_o = ~stopped;
endmodule

// ### hw/sdv_lock_det.sv
`timescale 1ns/1ps
module sdv_lock_det #(
   parameter int ERR_W = 8,
   parameter int LOCK_NS = sdv_pkg::LOCK_ERR_NS,
   parameter int UNLOCK_NS = sdv_pkg::UNLOCK_ERR_NS,
   parameter int CYCLES = sdv_pkg::LOCK_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic clear_i,
   // Phase detector sample
   input wire logic det_tick_i,
   input wire logic [ERR_W-1:0] phase_err_ns_i,
   // Result
   output logic locked_o
);
   localparam logic [ERR_W-1:0] LOCK_TH = ERR_W'(LOCK_NS);
   localparam logic [ERR_W-1:0] UNLOCK_TH = ERR_W'(UNLOCK_NS);
   localparam logic [3:0] CNT_TOP = 4'(CYCLES);

   logic [3:0] good_q;
   logic [3:0] good_d;
   logic lock_q;
   logic lock_d;
   wire small_err = (phase_err_ns_i < LOCK_TH);
   wire big_err = (phase_err_ns_i >= UNLOCK_TH);

   // Consecutive small errors; any other sample restarts the count
   assign good_d = !det_tick_i ? good_q :
                   !small_err ? 4'h0 :
                   (good_q == CNT_TOP) ? good_q : good_q + 4'h1;
   assign lock_d = !det_tick_i ? lock_q :
                   big_err ? 1'b0 :
                   (good_d == CNT_TOP) ? 1'b1 : lock_q;

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         good_q <= 4'h0;
         lock_q <= 1'b0;
      end
      else if (clear_i)
      begin
         good_q <= 4'h0;
         lock_q <= 1'b0;
      end
      else
      begin
         good_q <= good_d;
         lock_q <= lock_d;
      end
   end

   assign locked_o = lock_q;
endmodule

// ### hw/sdv_synth_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - Oscillator on by bit, default on, off when unpowered
// - Two-bit oscillator bias current field
// - Output clock divides by even 2 to 30
// - Output clock 50:50, toggles on rising reference edges
// - Output clock divider defaults to eight
// - Divide number zero stops output clock
// - Reference counter divides 1 to 7, clocks detector
// - Reference counter defaults to one
// - Eight-bit integer plus fifteen-bit fraction in word 0
// - Integer below 23 not valid
// - Output equals detector rate times integer plus fraction
// - Halving option halves the output relation
// - Integer at most 255, total division 256
// - Power enable low clears all settings
// - Three-bit field selects status pin source
// - Status pin defaults to regulator ready
// - Calibration done low during coarse and fine
// - Lock after five good cycles, drop at 25 ns
// - Direction low in transmit, high in receive
module sdv_synth_ctrl #(
   parameter int ERR_W = 8,
   parameter logic [2:0] CODE_REG_READY = sdv_pkg::SEL_REG_READY,
   parameter logic [2:0] CODE_CAL_DONE = sdv_pkg::SEL_CAL_DONE,
   parameter logic [2:0] CODE_LOCK = sdv_pkg::SEL_LOCK,
   parameter logic [2:0] CODE_TXRX = sdv_pkg::SEL_TXRX
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins and analog status
   input wire logic power_enable_i,
   input wire logic regulator_ready_i,
   input wire logic coarse_cal_busy_i,
   input wire logic fine_cal_busy_i,
   input wire logic rx_mode_i,
   input wire logic [ERR_W-1:0] phase_err_ns_i,
   // Oscillator and regulators
   output logic osc_enable_o,
   output logic [1:0] osc_bias_field_o,
   output logic regulator_enable_o,
   // Clocks
   output logic divided_ref_output_o,
   output logic phase_detector_tick_o,
   // Feedback divider
   output logic [7:0] n_integer_o,
   output logic [14:0] n_fraction_o,
   output logic output_half_select_o,
   output logic [23:0] fout_ratio_o,
   // Status pin
   output logic status_mux_pin_o
);
   // Input synchronisers
   logic [1:0] pwr_s_q;
   logic [1:0] rdy_s_q;
   logic [1:0] cal_s_q;
   logic [1:0] rx_s_q;
   logic [ERR_W-1:0] err_a_q;
   logic [ERR_W-1:0] err_b_q;
   logic [ERR_W-1:0] err_c_q;

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pwr_s_q <= 2'h0;
         rdy_s_q <= 2'h0;
         cal_s_q <= 2'h0;
         rx_s_q <= 2'h0;
         err_a_q <= '1;
         err_b_q <= '1;
         err_c_q <= '1;
      end
      else
      begin
         pwr_s_q <= {pwr_s_q[0], power_enable_i};
         rdy_s_q <= {rdy_s_q[0], regulator_ready_i};
         cal_s_q <= {cal_s_q[0], coarse_cal_busy_i | fine_cal_busy_i};
         rx_s_q <= {rx_s_q[0], rx_mode_i};
         err_a_q <= phase_err_ns_i;
         err_b_q <= err_a_q;
         // Error word passes only when two samples agree, no torn words
         err_c_q <= (err_a_q == err_b_q) ? err_b_q : err_c_q;
      end
   end

   wire powered = pwr_s_q[1];
   wire reg_ready = rdy_s_q[1];
   wire cal_done = ~cal_s_q[1];
   wire rx_mode = rx_s_q[1];

   // Configuration registers
   logic [14:0] frac_q;
   logic [7:0] int_q;
   logic [2:0] mux_q;
   logic [2:0] rdiv_q;
   logic [3:0] ckdiv_q;
   logic oscen_q;
   logic [1:0] bias_q;
   logic half_q;
   logic int_clamp_q;

   // Bus decode
   wire access = psel & penable;
   wire hit_cfg0 = (paddr == sdv_pkg::ADDR_CFG0);
   wire hit_cfg1 = (paddr == sdv_pkg::ADDR_CFG1);
   wire hit_stat = (paddr == sdv_pkg::ADDR_STAT);
   wire mapped = hit_cfg0 | hit_cfg1 | hit_stat;
   wire bad_write = pwrite & hit_stat;
   // Writes ignored until supply is up and ready
   wire wr_ok = access & pwrite & powered & reg_ready & (pstrb == 4'hF);
   wire wr0 = wr_ok & hit_cfg0;
   wire wr1 = wr_ok & hit_cfg1;

   wire [7:0] wr_int = pwdata[sdv_pkg::INT_LSB +: sdv_pkg::INT_W];
   wire int_low = (wr_int < sdv_pkg::INT_MIN);
   // Too small an integer is raised to the least valid value
   wire [7:0] int_new = int_low ? sdv_pkg::INT_MIN : wr_int;

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         frac_q <= sdv_pkg::FRAC_RST;
         int_q <= sdv_pkg::INT_RST;
         mux_q <= CODE_REG_READY;
         int_clamp_q <= 1'b0;
      end
      else if (!powered)
      begin
         frac_q <= sdv_pkg::FRAC_RST;
         int_q <= sdv_pkg::INT_RST;
         mux_q <= CODE_REG_READY;
         int_clamp_q <= 1'b0;
      end
      else if (wr0)
      begin
         frac_q <= pwdata[sdv_pkg::FRAC_LSB +: sdv_pkg::FRAC_W];
         int_q <= int_new;
         mux_q <= pwdata[sdv_pkg::MUX_LSB +: sdv_pkg::MUX_W];
         int_clamp_q <= int_low;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rdiv_q <= sdv_pkg::RDIV_RST;
         ckdiv_q <= sdv_pkg::CKDIV_RST;
         oscen_q <= sdv_pkg::OSCEN_RST;
         bias_q <= sdv_pkg::BIAS_RST;
         half_q <= sdv_pkg::HALF_RST;
      end
      else if (!powered)
      begin
         rdiv_q <= sdv_pkg::RDIV_RST;
         ckdiv_q <= sdv_pkg::CKDIV_RST;
         oscen_q <= sdv_pkg::OSCEN_RST;
         bias_q <= sdv_pkg::BIAS_RST;
         half_q <= sdv_pkg::HALF_RST;
      end
      else if (wr1)
      begin
         rdiv_q <= pwdata[sdv_pkg::RDIV_LSB +: sdv_pkg::RDIV_W];
         ckdiv_q <= pwdata[sdv_pkg::CKDIV_LSB +: sdv_pkg::CKDIV_W];
         oscen_q <= pwdata[sdv_pkg::OSCEN_BIT];
         bias_q <= pwdata[sdv_pkg::BIAS_LSB +: sdv_pkg::BIAS_W];
         half_q <= pwdata[sdv_pkg::HALF_BIT];
      end
   end

   // Oscillator, bias and regulator controls
   assign osc_enable_o = oscen_q & powered;
   assign osc_bias_field_o = bias_q;
   assign regulator_enable_o = powered;

   // Reference counter; a zero field acts as one
   logic [2:0] rcnt_q;
   logic det_q;
   wire [2:0] r_eff = (rdiv_q == 3'h0) ? 3'h1 : rdiv_q;
   wire r_wrap = (rcnt_q >= r_eff - 3'h1);
   wire osc_run = osc_enable_o;

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rcnt_q <= 3'h0;
         det_q <= 1'b0;
      end
      else if (!osc_run)
      begin
         rcnt_q <= 3'h0;
         det_q <= 1'b0;
      end
      else
      begin
         rcnt_q <= r_wrap ? 3'h0 : rcnt_q + 3'h1;
         det_q <= r_wrap;
      end
   end

   assign phase_detector_tick_o = det_q;

   // Output clock divider, stopped with the oscillator
   wire [3:0] ck_half = osc_run ? ckdiv_q : 4'h0;
   logic ck_running;

   sdv_outclk_div #(
      .DIV_W(4)
   ) u_outclk (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .half_period_i(ck_half),
      .clk_div_o(divided_ref_output_o),
      .running_o(ck_running)
   );

   // Lock detector on detector samples
   logic locked;

   sdv_lock_det #(
      .ERR_W(ERR_W)
   ) u_lock (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .clear_i(~osc_run),
      .det_tick_i(det_q),
      .phase_err_ns_i(err_c_q),
      .locked_o(locked)
   );

   // Feedback word, Q8.16: integer.fraction, halved when selected
   assign n_integer_o = int_q;
   assign n_fraction_o = frac_q;
   assign output_half_select_o = half_q;
   assign fout_ratio_o = half_q ? {1'b0, int_q, frac_q} : {int_q, frac_q, 1'b0};

   // Status pin source select
   logic mux_bit;
   always_comb
   begin
      case (mux_q)
         CODE_REG_READY: mux_bit = reg_ready;
         CODE_CAL_DONE: mux_bit = cal_done;
         CODE_LOCK: mux_bit = locked;
         CODE_TXRX: mux_bit = rx_mode;
         default: mux_bit = 1'b0;
      endcase
   end

   logic mux_q_pin;
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         mux_q_pin <= 1'b0;
      end
      else
      begin
         mux_q_pin <= mux_bit;
      end
   end

   assign status_mux_pin_o = mux_q_pin;

   // Read data
   wire [31:0] rd_cfg0 = {mux_q, 2'h0, int_q, frac_q, 4'h0};
   wire [31:0] rd_cfg1 = {13'h0000, half_q, 3'h0, bias_q, oscen_q, 1'b0, ckdiv_q, rdiv_q, 4'h0};
   wire [31:0] rd_stat = {25'h0000000, int_clamp_q, ck_running, rx_mode, cal_done,
                          locked, reg_ready, powered};
   wire [31:0] rd_mux = hit_cfg0 ? rd_cfg0 : hit_cfg1 ? rd_cfg1 : hit_stat ? rd_stat : 32'h0;

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         prdata <= 32'h00000000;
      end
      else if (psel & ~penable & ~pwrite)
      begin
         prdata <= rd_mux;
      end
   end

   assign pready = 1'b1;
   assign pslverr = access & (~mapped | bad_write);
endmodule

// ### tb/sdv_synth_checker.sv
`timescale 1ns/1ps
module sdv_synth_checker (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and settings
   input wire logic power_enable_i,
   input wire logic osc_enable_o,
   input wire logic [1:0] osc_bias_field_o,
   input wire logic regulator_enable_o,
   input wire logic divided_ref_output_o,
   input wire logic [7:0] n_integer_o,
   input wire logic [14:0] n_fraction_o,
   input wire logic output_half_select_o,
   input wire logic [23:0] fout_ratio_o
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);
   logic [4:0] hi_q;
   logic [4:0] hi_d;
   wire acc = psel && penable;
   wire cfg1_wr = acc && pwrite && paddr == sdv_pkg::ADDR_CFG1;
   wire ok_adr = paddr inside {sdv_pkg::ADDR_CFG0, sdv_pkg::ADDR_CFG1};
   wire bad = !ok_adr && !(paddr == sdv_pkg::ADDR_STAT && !pwrite);
   wire [23:0] full = {n_integer_o, n_fraction_o, 1'b0};
   // Length of the current high phase of the output clock
   assign hi_d = (divided_ref_output_o && osc_enable_o) ? hi_q + 5'h01 : 5'h00;
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
      if (!reset_n_i)
         hi_q <= 5'h00;
      else
         hi_q <= hi_d;
   sequence pwr_steady;
      $stable(power_enable_i) [*4];
   endsequence
   sequence coef_held;
      $stable(n_integer_o) && $stable(n_fraction_o) && $stable(output_half_select_o);
   endsequence
   pready_hi_a: assert property (acc |-> pready)
      else $error("pready low in access");
   bad_addr_a: assert property (acc && bad |-> pslverr)
      else $error("no error on bad access");
   osc_gate_a: assert property (!regulator_enable_o |-> !osc_enable_o)
      else $error("oscillator on while unpowered");
   int_floor_a: assert property (n_integer_o >= sdv_pkg::INT_MIN)
      else $error("integer below minimum");
   ratio_calc_a: assert property (coef_held |->
      fout_ratio_o == (output_half_select_o ? full >> 1 : full))
      else $error("ratio wrong");
   clk_high_a: assert property (hi_q <= 5'h0F)
      else $error("output clock high too long");
   pwr_follow_a: assert property (pwr_steady |-> regulator_enable_o == power_enable_i)
      else $error("regulators do not follow enable");
   bias_src_a: assert property ($changed(osc_bias_field_o) |->
      $past(cfg1_wr) || !$past(regulator_enable_o) || !regulator_enable_o)
      else $error("bias changed without write");
endmodule
bind sdv_synth_ctrl sdv_synth_checker chk_u (
   .clk_sys_i, .reset_n_i, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
   .power_enable_i, .osc_enable_o, .osc_bias_field_o, .regulator_enable_o,
   .divided_ref_output_o, .n_integer_o, .n_fraction_o, .output_half_select_o, .fout_ratio_o
);

// ### tb/sdv_mcu_model.sv
`timescale 1ns/1ps
module sdv_mcu_model (
   // Clock
   input wire logic clk_sys_i,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Chip enable and status pin
   output logic power_enable_o,
   input wire logic status_mux_pin_i
);
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      power_enable_o = 1'b1;
   end
   // Chip enable, then hold off until the status pin reports ready
   task automatic power(input logic on);
      power_enable_o <= on;
      while (on && status_mux_pin_i !== 1'b1)
      begin
         @(posedge clk_sys_i);
      end
      repeat (4) @(posedge clk_sys_i);
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
      end
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_i);
   endtask
endmodule

// ### tb/tb_synth_divider_and_status_mux.sv
`timescale 1ns/1ps
module tb_synth_divider_and_status_mux;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic regulator_ready_i = 1'b0;
   logic coarse_cal_busy_i = 1'b0;
   logic fine_cal_busy_i = 1'b0;
   logic rx_mode_i = 1'b0;
   logic [7:0] phase_err_ns_i = 8'h1E;
   logic psel, penable, pwrite, pready, pslverr, power_enable_i, status_mux_pin_o, err;
   logic osc_enable_o, regulator_enable_o, divided_ref_output_o, phase_detector_tick_o;
   logic output_half_select_o;
   logic [1:0] osc_bias_field_o;
   logic [3:0] pstrb;
   logic [7:0] paddr, n_integer_o;
   logic [14:0] n_fraction_o;
   logic [23:0] fout_ratio_o;
   logic [31:0] pwdata, prdata, m0, m1, d0, d1, q;
   int mismatches = 0;
   int checks_done = 0;
   int seed = 96;
   int up_cnt = 0;
   int n;
   sdv_synth_ctrl dut_u (
      .clk_sys_i, .reset_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .power_enable_i, .regulator_ready_i, .coarse_cal_busy_i,
      .fine_cal_busy_i, .rx_mode_i, .phase_err_ns_i, .osc_enable_o, .osc_bias_field_o,
      .regulator_enable_o, .divided_ref_output_o, .phase_detector_tick_o, .n_integer_o,
      .n_fraction_o, .output_half_select_o, .fout_ratio_o, .status_mux_pin_o
   );
   sdv_mcu_model mcu_u (
      .clk_sys_i, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .power_enable_o(power_enable_i), .status_mux_pin_i(status_mux_pin_o)
   );
   always #12.5 clk_sys_i = ~clk_sys_i;
   // Regulator settles a while after chip enable
   always @(posedge clk_sys_i)
   begin
      up_cnt <= power_enable_i ? up_cnt + 1 : 0;
      regulator_ready_i <= power_enable_i && up_cnt > 40;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic until_is(input bit w, input logic v, output int k);
      k = 0;
      do
      begin
         @(posedge clk_sys_i);
         k++;
      end
      while ((w ? phase_detector_tick_o : divided_ref_output_o) !== v && k < 200);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rq;
      logic re;
      mcu_u.xfer(1'b1, a, d, rq, re);
      if (a == sdv_pkg::ADDR_CFG1)
         m1 = d & 32'h0004_77F0;
      else
         m0 = {d[31:29], 2'b00, (d[26:19] < sdv_pkg::INT_MIN) ? sdv_pkg::INT_MIN : d[26:19],
            d[18:4], 4'h0};
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] rq;
      logic re;
      mcu_u.xfer(1'b0, a, 32'h0, rq, re);
      chk(rq, e);
   endtask
   task automatic verify();
      int k;
      logic [23:0] r;
      rd_chk(sdv_pkg::ADDR_CFG0, m0);
      rd_chk(sdv_pkg::ADDR_CFG1, m1);
      chk({5'h00, osc_enable_o, osc_bias_field_o, output_half_select_o, n_integer_o,
         n_fraction_o}, {5'h00, m1[12], m1[14:13], m1[18], m0[26:4]});
      r = {m0[26:4], 1'b0};
      chk({8'h00, fout_ratio_o}, {8'h00, m1[18] ? r >> 1 : r});
      if (m1[12] && m1[10:7] != 4'h0)
      begin
         until_is(1'b0, 1'b0, k);
         until_is(1'b0, 1'b1, k);
         until_is(1'b0, 1'b0, k);
         chk(k, {28'h0, m1[10:7]});
         until_is(1'b0, 1'b1, k);
         chk(k, {28'h0, m1[10:7]});
         until_is(1'b1, 1'b1, k);
         until_is(1'b1, 1'b1, k);
         chk(k, {29'h0, m1[6:4] == 3'h0 ? 3'h1 : m1[6:4]});
      end
   endtask
   task automatic dflt();
      m0 = 32'h00B8_0000;
      m1 = 32'h0000_1210;
      verify();
   endtask
   task automatic mux_case(input logic [2:0] c, input logic [2:0] s, input logic [7:0] e,
      input logic x);
      coarse_cal_busy_i <= s[0];
      fine_cal_busy_i <= s[1];
      rx_mode_i <= s[2];
      phase_err_ns_i <= e;
      wr(sdv_pkg::ADDR_CFG0, {c, 29'h00B8_0000});
      repeat (12) @(posedge clk_sys_i);
      chk({31'h0, status_mux_pin_o}, {31'h0, x});
   endtask
   initial
   begin
      repeat (6) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      mcu_u.power(1'b1);
      chk({31'h0, status_mux_pin_o}, 32'h1);
      dflt();
      for (int i = 0; i < 6; i++)
      begin
         d0 = $random(seed);
         d1 = $random(seed) | 32'h0000_1000;
         if (i == 0)
            d0[26:19] = 8'h16;
         if (i == 1)
            d0[26:4] = 23'h7F_FFFF;
         if (i == 2)
            d1[12] = 1'b0;
         wr(sdv_pkg::ADDR_CFG0, d0);
         wr(sdv_pkg::ADDR_CFG1, d1);
         verify();
      end
      wr(sdv_pkg::ADDR_CFG1, 32'h0000_1010);
      repeat (40) @(posedge clk_sys_i);
      until_is(1'b0, 1'b1, n);
      chk(n, 200);
      mcu_u.xfer(1'b0, 8'h0C, 32'h0, q, err);
      chk({31'h0, err}, 32'h1);
      mcu_u.xfer(1'b1, sdv_pkg::ADDR_STAT, 32'hFFFF_FFFF, q, err);
      chk({31'h0, err}, 32'h1);
      mux_case(sdv_pkg::SEL_CAL_DONE, 3'h0, 8'h1E, 1'b1);
      mux_case(sdv_pkg::SEL_CAL_DONE, 3'h1, 8'h1E, 1'b0);
      mux_case(sdv_pkg::SEL_CAL_DONE, 3'h2, 8'h1E, 1'b0);
      mux_case(sdv_pkg::SEL_TXRX, 3'h4, 8'h1E, 1'b1);
      mux_case(sdv_pkg::SEL_TXRX, 3'h0, 8'h05, 1'b0);
      mux_case(sdv_pkg::SEL_LOCK, 3'h0, 8'h05, 1'b1);
      mux_case(sdv_pkg::SEL_LOCK, 3'h0, 8'h18, 1'b1);
      mux_case(sdv_pkg::SEL_LOCK, 3'h0, 8'h19, 1'b0);
      mux_case(sdv_pkg::SEL_LOCK, 3'h0, 8'h0E, 1'b1);
      mux_case(3'h5, 3'h4, 8'h0E, 1'b0);
      mcu_u.power(1'b0);
      repeat (8) @(posedge clk_sys_i);
      chk({30'h0, osc_enable_o, regulator_enable_o}, 32'h0);
      mcu_u.power(1'b1);
      dflt();
      conclude();
   end
   initial
   begin
      #1000000;
      mismatches++;
      conclude();
   end
endmodule
